// ---- src/osc_pkg.sv ----
// package: register map, field positions, source codes and timing constants
package osc_pkg;

    // register word addresses on the plain register port
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLK_DIV = 4'h1;
    localparam logic [3:0] ADDR_PLL_FBD = 4'h2;

    // oscillator_control field positions
    localparam int CUR_SRC_LSB = 12;
    localparam int NEXT_SRC_LSB = 8;
    localparam int BIT_SRC_LOCK = 7;
    localparam int BIT_PIN_LOCK = 6;
    localparam int BIT_PLL_LOCK = 5;
    localparam int BIT_FAIL = 3;
    localparam int BIT_SEC_EN = 1;
    localparam int BIT_SW_REQ = 0;

    // clock divisor field positions
    localparam int RC_POSTDIV_LSB = 8;
    localparam int PLL_OUT_DIV_LSB = 6;
    localparam int PLL_PRE_LSB = 0;

    // values after reset
    localparam logic [2:0] RC_POSTDIV_RST = 3'h0;
    localparam logic [1:0] PLL_OUT_DIV_RST = 2'h1;
    localparam logic [4:0] PLL_PRE_RST = 5'h00;
    localparam logic [8:0] PLL_FBD_RST = 9'h030;

    // oscillator source encoding, shared by current and next selection
    localparam logic [2:0] SRC_RC = 3'h0;
    localparam logic [2:0] SRC_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_SLOW = 3'h5;
    localparam logic [2:0] SRC_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_RC_DIVN = 3'h7;

    // primary oscillator submodes
    localparam logic [1:0] PRI_EXT_CLK = 2'h0;
    localparam logic [1:0] PRI_STD_XTAL = 2'h1;
    localparam logic [1:0] PRI_HS_XTAL = 2'h2;

    // switching allowed, fail monitor off
    localparam logic [1:0] SWM_SWITCH_ONLY = 2'h1;

    // pll factor offsets and out divider codes
    localparam logic [5:0] PLL_PRE_OFFSET = 6'h02;
    localparam logic [9:0] PLL_FBD_OFFSET = 10'h002;
    localparam logic [1:0] N2_DIV2 = 2'h0;
    localparam logic [1:0] N2_DIV4 = 2'h1;
    localparam logic [1:0] N2_DIV8 = 2'h3;

    // divider ratios
    localparam int DIV_W = 9;
    localparam logic [8:0] RC_DIV16_RATIO = 9'h010;
    localparam logic [8:0] RC_DIV256_RATIO = 9'h100;
    localparam logic [2:0] RC_DIV256_CODE = 3'h7;
    localparam logic [8:0] INSTR_RATIO = 9'h002;

    // new-clock cycles waited before a switch takes effect
    localparam logic [3:0] SWITCH_WAIT_TICKS = 4'hA;

    // nominal low-power rc rate in hz, reference for watchdog and monitor
    localparam int SLOW_RC_HZ = 32768;

endpackage

// ---- src/tick_div_if.sv ----
// interface: tick stream and ratio between a user and a tick divider
`timescale 1ns/1ps
interface tick_div_if #(parameter int W = 9);
    logic tick_in; // one-cycle tick of the source clock
    logic [W-1:0] ratio; // divide factor, 0 and 1 pass through
    logic tick_out; // one tick per ratio input ticks

    modport src (output tick_in, output ratio, input tick_out);
    modport div (input tick_in, input ratio, output tick_out);
endinterface // tick_div_if

// ---- src/tick_divider.sv ----
// module: divides a tick stream by a programmable ratio
`timescale 1ns/1ps
module tick_divider
    import osc_pkg::*;
#(
    parameter int W = 9
)
(
    input wire logic clk,
    input wire logic rst_b,
    tick_div_if.div bus
);

    // all state of the divider
    typedef struct packed {
        logic [W-1:0] cnt; // ticks seen in this period
        logic out; // registered output tick
    } div_state_s;

    div_state_s st_q;
    div_state_s st_d;

    // next-state: count ticks, fire on the last one of a period
    always_comb
    begin
        st_d = st_q;
        st_d.out = 1'b0;
        if (bus.tick_in)
        begin
            // a lowered ratio mid-period fires at once instead of wrapping
            if (bus.ratio <= W'(1) || st_q.cnt >= bus.ratio - W'(1))
            begin
                st_d.cnt = '0;
                st_d.out = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign bus.tick_out = st_q.out;

endmodule // tick_divider

// ---- src/oscillator_select_and_pll.sv ----
// module: oscillator source selection, pll factors and control register
//
// Overview of operation
// - fast rc postscaled by chosen factor
// - slow rc feeds watchdog and fail monitor
// - power-on source from configuration straps
// - erased straps start fast rc divide-by-n
// - instruction clock is oscillator divided by two
// - pll prescale n1 from 2 to 33
// - pll output is input times m/(n1*n2)
// - current source read-only, shared encoding
// - submode selects hs, standard crystal, external
// - next source writable, loaded from straps
// - source lock blocks switching in the switch-only, monitor-off strap setting
// - pin select lock gates pin writes
// - lock flag shows pll lock state
// - fail flag set by monitor, software clears
// - secondary crystal enable bit
// - switch request set by software, hardware clears
// - prescale field encodes n1 minus two
// - out divider codes 2, 4, reserved, 8
// - postdiv codes double up, 111 is 256
// - wait ten new ticks then switch
`timescale 1ns/1ps
module oscillator_select_and_pll
    import osc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // configuration straps
    input wire logic [2:0] initial_source_cfg,
    input wire logic [1:0] primary_submode_cfg,
    input wire logic [1:0] switch_monitor_cfg,
    // oscillator ticks, one clk cycle each
    input wire logic fast_rc_tick,
    input wire logic primary_tick,
    input wire logic secondary_tick,
    input wire logic slow_rc_tick,
    input wire logic pll_tick,
    // oscillator and pll status
    input wire logic primary_ready,
    input wire logic pll_locked,
    input wire logic clock_fail_detect,
    // peripheral pin select write request
    input wire logic pin_select_write,
    output logic pin_select_write_ok,
    // oscillator controls
    output logic primary_enable,
    output logic [1:0] primary_submode,
    output logic secondary_osc_on,
    output logic pll_enable,
    output logic pll_ref_primary,
    output logic [5:0] pll_n1,
    output logic [9:0] pll_m,
    output logic [3:0] pll_n2,
    // derived clocks
    output logic osc_tick,
    output logic instruction_tick,
    output logic watchdog_ref_tick,
    output logic monitor_ref_tick,
    output logic monitor_enable
);

    // switch sequence states
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_READY,
        SW_COUNT
    } switch_e;

    // all state of the block
    typedef struct packed {
        logic cfg_loaded; // straps captured after reset release
        logic [1:0] submode; // captured primary submode
        logic [1:0] swm; // captured switch/monitor setting
        logic [2:0] cur_src; // current source
        logic [2:0] next_src; // requested source
        logic src_lock; // source lock bit
        logic pin_lock; // pin select lock bit
        logic fail; // clock fail flag
        logic sec_en; // secondary oscillator enable
        logic sw_req; // switch request bit
        logic [2:0] rc_postdiv; // fast rc postscaler code
        logic [1:0] pll_out_div; // n2 code
        logic [4:0] pll_pre; // n1 code
        logic [8:0] pll_fbd; // m code
        switch_e sw_state; // switch sequence state
        logic [3:0] sw_cnt; // new-clock ticks counted
        logic [15:0] rdata; // read data register
    } osc_state_s;

    osc_state_s st_q;
    osc_state_s st_d;

    // divider links
    tick_div_if #(.W(DIV_W)) rc_div ();
    tick_div_if #(.W(DIV_W)) cy_div ();

    logic switch_allowed; // switching enabled by strap
    logic switch_blocked; // source lock holds the clock
    logic pll_in_use; // current or target source uses the pll
    logic target_ready; // target oscillator is usable
    logic target_tick; // tick of the target source
    logic [15:0] osc_ctrl_word;
    logic [15:0] clk_div_word;
    logic [15:0] pll_fbd_word;

    // true for the two pll source codes
    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == SRC_RC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    // true for the two primary source codes
    function automatic logic uses_primary(input logic [2:0] src);
        uses_primary = (src == SRC_PRI) || (src == SRC_PRI_PLL);
    endfunction

    // postscaler code to ratio: doubling codes, top code is 256
    function automatic logic [8:0] postdiv_ratio(input logic [2:0] code);
        if (code == RC_DIV256_CODE)
            postdiv_ratio = RC_DIV256_RATIO;
        else
            postdiv_ratio = 9'(9'h001 << code);
    endfunction

    // raw tick of a source before the fast rc postscaler
    function automatic logic raw_tick(input logic [2:0] src);
        case (src)
            SRC_RC, SRC_RC_DIV16, SRC_RC_DIVN: raw_tick = fast_rc_tick;
            SRC_RC_PLL, SRC_PRI_PLL: raw_tick = pll_tick;
            SRC_PRI: raw_tick = primary_tick;
            SRC_SEC: raw_tick = secondary_tick;
            SRC_SLOW: raw_tick = slow_rc_tick;
            default: raw_tick = 1'b0;
        endcase
    endfunction

    // switching allowed only when the upper strap bit is clear
    assign switch_allowed = !st_q.swm[1];
    assign switch_blocked = (st_q.swm == SWM_SWITCH_ONLY) && st_q.src_lock;
    assign pll_in_use = uses_pll(st_q.cur_src)
        || (st_q.sw_state != SW_IDLE && uses_pll(st_q.next_src));

    // target readiness and tick; process form keeps every tick in view
    always_comb
    begin
        target_tick = raw_tick(st_q.next_src);
        target_ready = 1'b1;
        if (uses_pll(st_q.next_src) && !pll_locked)
            target_ready = 1'b0;
        if (uses_primary(st_q.next_src) && st_q.submode != PRI_EXT_CLK && !primary_ready)
            target_ready = 1'b0;
    end

    // register images as software sees them
    always_comb
    begin
        osc_ctrl_word = '0;
        osc_ctrl_word[CUR_SRC_LSB +: 3] = st_q.cur_src;
        osc_ctrl_word[NEXT_SRC_LSB +: 3] = st_q.next_src;
        osc_ctrl_word[BIT_SRC_LOCK] = st_q.src_lock;
        osc_ctrl_word[BIT_PIN_LOCK] = st_q.pin_lock;
        // lock flag only while pll is on and locked
        osc_ctrl_word[BIT_PLL_LOCK] = pll_in_use && pll_locked;
        osc_ctrl_word[BIT_FAIL] = st_q.fail;
        osc_ctrl_word[BIT_SEC_EN] = st_q.sec_en;
        osc_ctrl_word[BIT_SW_REQ] = st_q.sw_req;
        clk_div_word = '0;
        clk_div_word[RC_POSTDIV_LSB +: 3] = st_q.rc_postdiv;
        clk_div_word[PLL_OUT_DIV_LSB +: 2] = st_q.pll_out_div;
        clk_div_word[PLL_PRE_LSB +: 5] = st_q.pll_pre;
        pll_fbd_word = {7'h00, st_q.pll_fbd};
    end

    // next-state: strap capture, register writes, switch sequence
    always_comb
    begin
        st_d = st_q;
        // straps taken in the first cycle after reset release
        if (!st_q.cfg_loaded)
        begin
            st_d.cfg_loaded = 1'b1;
            st_d.submode = primary_submode_cfg;
            st_d.swm = switch_monitor_cfg;
            st_d.cur_src = initial_source_cfg;
            st_d.next_src = initial_source_cfg;
        end
        // register writes
        if (reg_write && st_q.cfg_loaded)
        begin
            case (reg_addr)
                ADDR_OSC_CTRL:
                begin
                    st_d.next_src = reg_wdata[NEXT_SRC_LSB +: 3];
                    st_d.src_lock = reg_wdata[BIT_SRC_LOCK];
                    st_d.pin_lock = reg_wdata[BIT_PIN_LOCK];
                    if (!reg_wdata[BIT_FAIL])
                        st_d.fail = 1'b0;
                    st_d.sec_en = reg_wdata[BIT_SEC_EN];
                    if (reg_wdata[BIT_SW_REQ] && switch_allowed && !switch_blocked)
                        st_d.sw_req = 1'b1;
                end
                ADDR_CLK_DIV:
                begin
                    st_d.rc_postdiv = reg_wdata[RC_POSTDIV_LSB +: 3];
                    st_d.pll_out_div = reg_wdata[PLL_OUT_DIV_LSB +: 2];
                    st_d.pll_pre = reg_wdata[PLL_PRE_LSB +: 5];
                end
                ADDR_PLL_FBD:
                begin
                    st_d.pll_fbd = reg_wdata[8:0];
                end
                default:
                begin
                    // unmapped write ignored
                    st_d.rdata = st_q.rdata;
                end
            endcase
        end
        // switch sequence
        case (st_q.sw_state)
            SW_IDLE:
            begin
                if (st_q.sw_req)
                begin
                    if (st_q.next_src == st_q.cur_src)
                    begin
                        st_d.sw_req = 1'b0;
                    end
                    else
                    begin
                        // valid switch clears the fail flag
                        st_d.fail = 1'b0;
                        st_d.sw_cnt = '0;
                        st_d.sw_state = SW_READY;
                    end
                end
            end
            SW_READY:
            begin
                // wait for crystal start-up or pll lock
                if (target_ready)
                    st_d.sw_state = SW_COUNT;
            end
            SW_COUNT:
            begin
                // count ten ticks of the new clock
                if (target_tick)
                begin
                    if (st_q.sw_cnt == SWITCH_WAIT_TICKS - 4'h1)
                    begin
                        st_d.cur_src = st_q.next_src;
                        st_d.sw_req = 1'b0;
                        st_d.sw_state = SW_IDLE;
                    end
                    else
                    begin
                        st_d.sw_cnt = st_q.sw_cnt + 4'h1;
                    end
                end
            end
            default:
            begin
                st_d.sw_state = SW_IDLE;
            end
        endcase
        // switching disabled: request held at zero
        if (!switch_allowed)
            st_d.sw_req = 1'b0;
        // monitor event wins over any clear
        if (clock_fail_detect && st_q.cfg_loaded && st_q.swm == 2'h0)
            st_d.fail = 1'b1;
        // read data, valid the cycle after the strobe
        st_d.rdata = '0;
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_OSC_CTRL: st_d.rdata = osc_ctrl_word;
                ADDR_CLK_DIV: st_d.rdata = clk_div_word;
                ADDR_PLL_FBD: st_d.rdata = pll_fbd_word;
                default: st_d.rdata = '0;
            endcase
        end
    end

    // state register; reset defaults match an erased part
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            // erased default is fast rc divide-by-n
            st_q.cur_src <= SRC_RC_DIVN;
            st_q.next_src <= SRC_RC_DIVN;
            st_q.swm <= 2'h3;
            st_q.rc_postdiv <= RC_POSTDIV_RST;
            st_q.pll_out_div <= PLL_OUT_DIV_RST;
            st_q.pll_pre <= PLL_PRE_RST;
            st_q.pll_fbd <= PLL_FBD_RST;
            st_q.sw_state <= SW_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // fast rc postscaler, fixed sixteen in the divide-by-16 mode
    assign rc_div.tick_in = fast_rc_tick;
    assign rc_div.ratio = (st_q.cur_src == SRC_RC_DIV16) ? RC_DIV16_RATIO
        : postdiv_ratio(st_q.rc_postdiv);

    tick_divider #(.W(DIV_W)) u_rc_div (
        .clk(clk),
        .rst_b(rst_b),
        .bus(rc_div)
    );

    // oscillator tick: postscaled fast rc or the raw source
    always_comb
    begin
        if (st_q.cur_src == SRC_RC_DIV16 || st_q.cur_src == SRC_RC_DIVN)
            osc_tick = rc_div.tick_out;
        else
            osc_tick = raw_tick(st_q.cur_src);
    end

    // instruction clock is oscillator over two
    assign cy_div.tick_in = osc_tick;
    assign cy_div.ratio = INSTR_RATIO;

    tick_divider #(.W(DIV_W)) u_cy_div (
        .clk(clk),
        .rst_b(rst_b),
        .bus(cy_div)
    );

    assign instruction_tick = cy_div.tick_out;

    // slow rc reference for watchdog and monitor
    assign watchdog_ref_tick = slow_rc_tick;
    assign monitor_ref_tick = slow_rc_tick;
    assign monitor_enable = st_q.cfg_loaded && (st_q.swm == 2'h0);

    // pin select writes pass only when unlocked
    assign pin_select_write_ok = pin_select_write && !st_q.pin_lock;

    // oscillator enables
    assign primary_enable = uses_primary(st_q.cur_src)
        || (st_q.sw_state != SW_IDLE && uses_primary(st_q.next_src));
    assign primary_submode = st_q.submode;
    // secondary runs when enabled or selected
    assign secondary_osc_on = st_q.sec_en || st_q.cur_src == SRC_SEC
        || (st_q.sw_state != SW_IDLE && st_q.next_src == SRC_SEC);
    assign pll_enable = pll_in_use;
    assign pll_ref_primary = (st_q.sw_state != SW_IDLE) ? uses_primary(st_q.next_src)
        : uses_primary(st_q.cur_src);

    // pll factors for fosc = fin * m / (n1 * n2)
    assign pll_n1 = {1'b0, st_q.pll_pre} + PLL_PRE_OFFSET;
    assign pll_m = {1'b0, st_q.pll_fbd} + PLL_FBD_OFFSET;

    // out divider decode, reserved code reads as zero
    always_comb
    begin
        case (st_q.pll_out_div)
            N2_DIV2: pll_n2 = 4'h2;
            N2_DIV4: pll_n2 = 4'h4;
            N2_DIV8: pll_n2 = 4'h8;
            default: pll_n2 = 4'h0;
        endcase
    end

    assign reg_rdata = st_q.rdata;

endmodule // oscillator_select_and_pll

// ---- bench/osc_checker_assertions.sv ----
// checker: port properties of the oscillator control block
`timescale 1ns/1ps
module osc_checker
    import osc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] switch_monitor_cfg,
    input wire logic slow_rc_tick,
    input wire logic pin_select_write,
    input wire logic pin_select_write_ok,
    input wire logic secondary_osc_on,
    input wire logic [5:0] pll_n1,
    input wire logic [9:0] pll_m,
    input wire logic [3:0] pll_n2,
    input wire logic osc_tick,
    input wire logic instruction_tick,
    input wire logic watchdog_ref_tick,
    input wire logic monitor_ref_tick,
    input wire logic monitor_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // osc ticks less twice the instruction ticks
    int bal_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            bal_q <= 0;
        else
            bal_q <= bal_q + int'(osc_tick) - 2 * int'(instruction_tick);
    end
    a_instr_half: assert property (bal_q >= -1 && bal_q <= 2)
        else $error("instruction rate wrong");
    a_wdog_ref: assert property (watchdog_ref_tick == slow_rc_tick)
        else $error("watchdog reference differs");
    a_mon_ref: assert property (monitor_ref_tick == slow_rc_tick)
        else $error("monitor reference differs");
    a_mon_enable: assert property ($past(rst_b) |-> monitor_enable == (switch_monitor_cfg == 2'h0))
        else $error("monitor enable wrong");
    a_pin_gate: assert property (pin_select_write_ok |-> pin_select_write)
        else $error("stray pin grant");
    a_sec_set: assert property ($past(reg_write && reg_wdata[1] && reg_addr == 4'h0)
        |-> secondary_osc_on) else $error("secondary not enabled");
    a_n1_range: assert property (pll_n1 >= 6'h02 && pll_n1 <= 6'h21)
        else $error("prescale out of range");
    a_n2_set: assert property (pll_n2 inside {4'h0, 4'h2, 4'h4, 4'h8})
        else $error("postscale not 2, 4 or 8");
    a_m_range: assert property (pll_m >= 10'h002 && pll_m <= 10'h201)
        else $error("feedback out of range");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("stray read data");
    a_rsv_zero: assert property ($past(reg_read) && $past(reg_addr) == ADDR_OSC_CTRL
        |-> (reg_rdata & 16'h8814) == 16'h0000)
        else $error("reserved bits set");
    c_instr: cover property (instruction_tick);
    c_pin_deny: cover property (pin_select_write && !pin_select_write_ok);
    c_req_seen: cover property ($past(reg_read) && reg_rdata[BIT_SW_REQ]);
endmodule // osc_checker

bind oscillator_select_and_pll osc_checker u_chk (.*);

// ---- bench/osc_partner.sv ----
// model: oscillators and pll outside the clock control block
`timescale 1ns/1ps
module osc_partner #(
    parameter int LOCK_DLY = 16, // pll settle cycles
    parameter int START_DLY = 24 // crystal start-up cycles
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic primary_enable,
    input wire logic secondary_osc_on,
    input wire logic pll_enable,
    output logic fast_rc_tick,
    output logic primary_tick,
    output logic secondary_tick,
    output logic slow_rc_tick,
    output logic pll_tick,
    output logic primary_ready,
    output logic pll_locked
);
    int cnt_q; // free-running cycle count
    int pri_q; // cycles since crystal enable
    int pll_q; // cycles since pll enable
    // counters restart on reset; crystal and pll counts also on disable
    always_ff @(posedge clk)
    begin
        cnt_q <= rst_b ? cnt_q + 1 : 0;
        pri_q <= (rst_b && primary_enable) ? pri_q + 1 : 0;
        pll_q <= (rst_b && pll_enable) ? pll_q + 1 : 0;
    end
    assign fast_rc_tick = 1'b1;
    // primary crystal runs only once started, secondary as soon as it is on
    assign primary_tick = primary_ready && cnt_q[0];
    assign secondary_tick = secondary_osc_on && cnt_q[1:0] == 2'h3;
    assign slow_rc_tick = cnt_q[1:0] == 2'h0;
    assign pll_tick = pll_locked;
    assign primary_ready = pri_q >= START_DLY;
    assign pll_locked = pll_q >= LOCK_DLY;
endmodule // osc_partner

// ---- bench/oscillator_select_and_pll_tb_top.sv ----
// testbench: registers, dividers, switching and flags
`timescale 1ns/1ps
module oscillator_select_and_pll_tb_top
    import osc_pkg::*;
;
    logic clk, rst_b, reg_write, reg_read, clock_fail_detect, pin_select_write;
    logic fast_rc_tick, primary_tick, secondary_tick, slow_rc_tick, pll_tick;
    logic primary_ready, pll_locked, pin_select_write_ok, primary_enable;
    logic secondary_osc_on, pll_enable, pll_ref_primary, osc_tick, instruction_tick;
    logic watchdog_ref_tick, monitor_ref_tick, monitor_enable;
    logic [3:0] reg_addr, pll_n2;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [2:0] initial_source_cfg;
    logic [1:0] primary_submode_cfg, switch_monitor_cfg, primary_submode;
    logic [5:0] pll_n1;
    logic [9:0] pll_m;
    logic [16:0] seed = 17'h104C7; // lfsr state
    logic [15:0] exp_q[$], msk_q[$]; // pending read notes
    logic rd_pend = 1'b0;
    int fail_count = 0, tests_run = 0, cyc = 0, n, no, ni, e;
    int n2_tbl[4] = '{2, 4, 0, 8};
    oscillator_select_and_pll uut (.*);
    osc_partner u_osc (.*);
    // 25 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rst(input logic [2:0] s, input logic [1:0] p, input logic [1:0] w);
        initial_source_cfg <= s;
        primary_submode_cfg <= p;
        switch_monitor_cfg <= w;
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    // read, noting value and mask
    task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m);
        exp_q.push_back(x);
        msk_q.push_back(m);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    // switch, poll, check source
    task automatic sw(input logic [2:0] s);
        wr(ADDR_OSC_CTRL, {5'h00, s, 8'h03});
        n = 0;
        v = 16'h0001;
        while (v[0] && n < 200)
        begin
            rd(ADDR_OSC_CTRL, 16'h0000, 16'h0000);
            n++;
        end
        rd(ADDR_OSC_CTRL, {1'b0, s, 1'b0, s, 2'h0, s == SRC_RC_PLL || s == SRC_PRI_PLL,
            5'h00}, 16'h7721);
    endtask
    // monitor: checks oldest note, cuts hangs
    always @(posedge clk)
    begin : mon
        logic [15:0] m;
        cyc++;
        if (rd_pend)
        begin
            m = msk_q.pop_front();
            chk(reg_rdata & m, exp_q.pop_front() & m);
        end
        rd_pend = reg_read;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    initial
    begin
        {reg_write, reg_read, clock_fail_detect, pin_select_write} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        rst(SRC_RC_DIVN, PRI_STD_XTAL, SWM_SWITCH_ONLY);
        rd(ADDR_OSC_CTRL, 16'h7700, 16'hFFFF);
        rd(ADDR_CLK_DIV, 16'h0040, 16'hFFFF);
        rd(ADDR_PLL_FBD, 16'h0030, 16'hFFFF);
        wr(4'h3, 16'hFFFF);
        rd(4'h3, 16'h0000, 16'hFFFF);
        wr(ADDR_OSC_CTRL, 16'h2700);
        rd(ADDR_OSC_CTRL, 16'h7700, 16'hFFFF);
        for (int i = 0; i < 32; i++)
        begin
            wr(ADDR_CLK_DIV, {8'h00, 2'h1, 1'b0, i[4:0]});
            chk(pll_n1, i + 2);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CLK_DIV, {8'h00, i[1:0], 6'h00});
            chk(pll_n2, n2_tbl[i]);
        end
        repeat (8)
        begin
            seed = lfsr(seed);
            wr(ADDR_PLL_FBD, {7'h00, seed[8:0]});
            chk(pll_m, seed[8:0] + 2);
            rd(ADDR_PLL_FBD, {7'h00, seed[8:0]}, 16'hFFFF);
        end
        // default factors keep the pll in range
        wr(ADDR_PLL_FBD, 16'h0030);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_CLK_DIV, {5'h00, c[2:0], 8'h40});
            no = 0;
            ni = 0;
            repeat (512)
            begin
                @(posedge clk);
                no += osc_tick;
                ni += instruction_tick;
            end
            e = (c == 7) ? 2 : 512 >> c;
            chk(no >= e - 1 && no <= e + 1, 1);
            chk(ni >= e / 2 - 1 && ni <= e / 2 + 1, 1);
        end
        wr(ADDR_OSC_CTRL, 16'h0742);
        pin_select_write <= 1'b1;
        @(posedge clk);
        chk(pin_select_write_ok, 0);
        chk(secondary_osc_on, 1);
        wr(ADDR_OSC_CTRL, 16'h0700);
        chk(pin_select_write_ok, 1);
        chk(secondary_osc_on, 0);
        pin_select_write <= 1'b0;
        for (int s = 0; s < 8; s++)
        begin
            sw(s[2:0]);
            chk({pll_enable, pll_ref_primary}, {s == 1 || s == 3, s == 2 || s == 3});
            if (s == 5)
                chk(n >= 17 && n <= 28, 1);
        end
        sw(SRC_RC_DIVN);
        chk(n <= 2, 1);
        wr(ADDR_OSC_CTRL, 16'h0780);
        wr(ADDR_OSC_CTRL, 16'h0581);
        repeat (60) @(posedge clk);
        rd(ADDR_OSC_CTRL, 16'h7000, 16'h7001);
        wr(ADDR_OSC_CTRL, 16'h0700);
        rst(SRC_PRI, PRI_HS_XTAL, 2'h0);
        rd(ADDR_OSC_CTRL, 16'h2200, 16'hFFFF);
        chk(primary_submode, PRI_HS_XTAL);
        chk(primary_enable, 1);
        clock_fail_detect <= 1'b1;
        @(posedge clk);
        clock_fail_detect <= 1'b0;
        rd(ADDR_OSC_CTRL, 16'h0008, 16'h0008);
        wr(ADDR_OSC_CTRL, 16'h0208);
        rd(ADDR_OSC_CTRL, 16'h0008, 16'h0008);
        wr(ADDR_OSC_CTRL, 16'h0200);
        rd(ADDR_OSC_CTRL, 16'h0000, 16'h0008);
        end_sim();
    end
endmodule // oscillator_select_and_pll_tb_top
